// ===== rtl/ccs_params.svh
// Summary of operation
// - Code 000 picks the fast crystal and 001 the slow crystal, both fields.
// - Core field code 010 routes the PLL output to the core clock.
// - Core field code 011 routes the 10 kHz internal oscillator to core.
// - Core field code 111 routes the undivided fast internal oscillator to core.
// - Tick field code 010 feeds the tick timer the fast crystal over two.
// - Tick field code 011 feeds the tick timer the core clock over two.
// - Tick field code 111 feeds the tick timer the fast oscillator over two.
// - Tick field choice applies only while tick control bit 2 is zero.
// - Writes to either source field are ignored unless protection is open.
// - Any reset reloads the core field from the boot config field: 000 or 111.
// - A core switch sets the fail flag if target is unstable, else clears.
// - Writing one to the fail flag clears it.
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
// ==========================================================
// register map
`define CCS_OFF_UNLOCK 8'h00
`define CCS_OFF_STATUS 8'h0C
`define CCS_OFF_SEL0 8'h10
// ==========================================================
// fields
`define CCS_CORE_LSB 0
`define CCS_CORE_MSB 2
`define CCS_TICK_LSB 3
`define CCS_TICK_MSB 5
`define CCS_FAIL_BIT 7
`define CCS_TICK_RESET 3'h7
`define CCS_CORE_RESET 3'h7
// ==========================================================
// source codes
`define CCS_C_HXT 3'h0
`define CCS_C_LXT 3'h1
`define CCS_C_PLL 3'h2
`define CCS_C_LIRC 3'h3
`define CCS_C_HIRC 3'h7
`define CCS_T_HXT2 3'h2
`define CCS_T_HCLK2 3'h3
// ==========================================================
// unlock bytes and write/read response codes
`define CCS_KEY1 8'h59
`define CCS_KEY2 8'h16
`define CCS_KEY3 8'h88
`define CCS_RESP_OK 2'h0
`define CCS_RESP_ERR 2'h2
`endif

// ===== rtl/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
    typedef logic [2:0] ccs_code_t;
    typedef logic [4:0] ccs_sel_t;
    typedef enum logic [1:0] {
        CCS_LOCKED = 2'b00,
        CCS_GOT1 = 2'b01,
        CCS_GOT2 = 2'b10,
        CCS_OPEN = 2'b11
    } ccs_lock_t;
endpackage : ccs_pkg
`default_nettype wire

// ===== rtl/ccs_sel_if.sv
`default_nettype none
interface ccs_sel_if;
    import ccs_pkg::*;
    ccs_code_t core_code;
    ccs_code_t tick_code;
    ccs_sel_t core_sel;
    ccs_sel_t tick_sel;
    modport ctl (output core_code, output tick_code, input core_sel, input tick_sel);
    modport dec (input core_code, input tick_code, output core_sel, output tick_sel);
endinterface : ccs_sel_if
`default_nettype wire

// ===== rtl/ccs_clk_mux.sv
`include "ccs_params.svh"
`default_nettype none
// one-hot order, core: hxt, lxt, pll, lirc, hirc
// one-hot order, tick: hxt, lxt, hxt/2, hclk/2, hirc/2
module ccs_clk_mux
    import ccs_pkg::*;
(
    ccs_sel_if.dec sel
);
    // ==========================================================
    // decoders
    function automatic ccs_sel_t core_dec(input ccs_code_t c);
        ccs_sel_t s;
        s = 5'h00;
        unique case (c)
            `CCS_C_HXT: s = 5'h01;
            `CCS_C_LXT: s = 5'h02;
            `CCS_C_PLL: s = 5'h04;
            `CCS_C_LIRC: s = 5'h08;
            `CCS_C_HIRC: s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction : core_dec

    function automatic ccs_sel_t tick_dec(input ccs_code_t c);
        ccs_sel_t s;
        s = 5'h00;
        unique case (c)
            `CCS_C_HXT: s = 5'h01;
            `CCS_C_LXT: s = 5'h02;
            `CCS_T_HXT2: s = 5'h04;
            `CCS_T_HCLK2: s = 5'h08;
            `CCS_C_HIRC: s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction : tick_dec

    // ==========================================================
    // select outputs
    // core and tick decode
    assign sel.core_sel = core_dec(sel.core_code);
    assign sel.tick_sel = tick_dec(sel.tick_code);
endmodule : ccs_clk_mux
`default_nettype wire

// ===== rtl/ccs_top.sv
`include "ccs_params.svh"
`default_nettype none
module ccs_top
    import ccs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // system side
    input wire logic [2:0] boot_clock_config_field,
    input wire logic tick_src_is_core,
    input wire logic [4:0] osc_stable,
    // clock selects
    output logic [4:0] core_sel,
    output logic [4:0] tick_sel
);
    // ==========================================================
    // state
    ccs_sel_if sel_bus ();
    ccs_code_t core_code_reg;
    ccs_code_t tick_code_reg;
    ccs_lock_t lock_reg;
    ccs_lock_t lock_next;
    logic boot_done_reg;
    logic fail_reg;
    logic [4:0] stb_meta_reg;
    logic [4:0] stb_sync_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic sel0_wr;
    logic core_switch;
    logic fail_clear;
    logic unlocked;
    logic [31:0] rd_value;
    default clocking chk_clk @(posedge clock);
    endclocking
    default disable iff (!rstn);

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == `CCS_OFF_UNLOCK) || (a == `CCS_OFF_STATUS) || (a == `CCS_OFF_SEL0);
    endfunction : addr_mapped

    ccs_clk_mux u_mux (
        .sel(sel_bus.dec)
    );

    assign sel_bus.core_code = core_code_reg;
    assign sel_bus.tick_code = tick_code_reg;
    assign unlocked = (lock_reg == CCS_OPEN);
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid;
    assign sel0_wr = wr_fire && (waddr_reg == `CCS_OFF_SEL0) && wstrb_reg[0];
    assign core_switch = sel0_wr && unlocked;
    assign fail_clear = wr_fire && (waddr_reg == `CCS_OFF_STATUS) && wstrb_reg[0]
        && wdata_reg[`CCS_FAIL_BIT];

    // ==========================================================
    // oscillator stable synchroniser
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stb_meta_reg <= 5'h00;
            stb_sync_reg <= 5'h00;
        end
        else
        begin
            stb_meta_reg <= osc_stable;
            stb_sync_reg <= stb_meta_reg;
        end
    end

    // ==========================================================
    // write channel capture
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_hold_reg <= 1'b0;
            awready <= 1'b1;
            waddr_reg <= 8'h00;
        end
        else if (awvalid && awready)
        begin
            aw_hold_reg <= 1'b1;
            awready <= 1'b0;
            waddr_reg <= awaddr;
        end
        else if (wr_fire)
            aw_hold_reg <= 1'b0;
        else if (bvalid && bready)
            awready <= 1'b1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            w_hold_reg <= 1'b0;
            wready <= 1'b1;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            w_hold_reg <= 1'b1;
            wready <= 1'b0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end
        else if (wr_fire)
            w_hold_reg <= 1'b0;
        else if (bvalid && bready)
            wready <= 1'b1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid <= 1'b0;
            bresp <= `CCS_RESP_OK;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= addr_mapped(waddr_reg) ? `CCS_RESP_OK : `CCS_RESP_ERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // ==========================================================
    // unlock sequence
    always_comb
    begin
        lock_next = lock_reg;
        if (wr_fire && (waddr_reg == `CCS_OFF_UNLOCK) && wstrb_reg[0])
        begin
            lock_next = (wdata_reg[7:0] == `CCS_KEY1) ? CCS_GOT1 : CCS_LOCKED;
            unique case (lock_reg)
                CCS_GOT1:
                    if (wdata_reg[7:0] == `CCS_KEY2)
                        lock_next = CCS_GOT2;
                CCS_GOT2:
                    if (wdata_reg[7:0] == `CCS_KEY3)
                        lock_next = CCS_OPEN;
                CCS_LOCKED, CCS_OPEN:
                    lock_next = lock_next;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            lock_reg <= CCS_LOCKED;
        else
            lock_reg <= lock_next;
    end

    // ==========================================================
    // source select fields
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_done_reg <= 1'b0;
            core_code_reg <= `CCS_CORE_RESET;
            tick_code_reg <= `CCS_TICK_RESET;
        end
        else if (!boot_done_reg)
        begin
            boot_done_reg <= 1'b1;
            core_code_reg <= (boot_clock_config_field == `CCS_C_HXT) ? `CCS_C_HXT
                : `CCS_C_HIRC;
        end
        else if (core_switch)
        begin
            core_code_reg <= wdata_reg[`CCS_CORE_MSB:`CCS_CORE_LSB];
            tick_code_reg <= wdata_reg[`CCS_TICK_MSB:`CCS_TICK_LSB];
        end
    end

    // ==========================================================
    // switch fail flag
    // switch result, wins over a clear
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            fail_reg <= 1'b0;
        else if (core_switch)
            fail_reg <= !(|(stb_sync_reg & core_dec_w(wdata_reg[`CCS_CORE_MSB:`CCS_CORE_LSB])));
        else if (fail_clear)
            fail_reg <= 1'b0;
    end

    // stability lookup of a requested code; unlisted codes count as unstable
    function automatic ccs_sel_t core_dec_w(input ccs_code_t c);
        ccs_sel_t s;
        s = 5'h00;
        unique case (c)
            `CCS_C_HXT: s = 5'h01;
            `CCS_C_LXT: s = 5'h02;
            `CCS_C_PLL: s = 5'h04;
            `CCS_C_LIRC: s = 5'h08;
            `CCS_C_HIRC: s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction : core_dec_w

    // ==========================================================
    // select outputs, registered
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            core_sel <= 5'h00;
            tick_sel <= 5'h00;
        end
        else
        begin
            core_sel <= sel_bus.core_sel;
            // tick timer on core clock when bit 2 set
            tick_sel <= tick_src_is_core ? 5'h00 : sel_bus.tick_sel;
        end
    end

    // ==========================================================
    // read channel
    always_comb
    begin
        unique case (araddr)
            `CCS_OFF_UNLOCK: rd_value = {31'h0000_0000, unlocked};
            `CCS_OFF_STATUS: rd_value = {24'h00_0000, fail_reg, 2'h0, stb_sync_reg};
            `CCS_OFF_SEL0: rd_value = {26'h000_0000, tick_code_reg, core_code_reg};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `CCS_RESP_OK;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_value;
            rresp <= addr_mapped(araddr) ? `CCS_RESP_OK : `CCS_RESP_ERR;
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    property p_core_hxt;
        core_code_reg == `CCS_C_HXT |=> core_sel == 5'h01;
    endproperty
    a_core_hxt: assert property (p_core_hxt) else $error("core 000 not fast crystal");

    property p_core_pll;
        core_code_reg == `CCS_C_PLL |=> core_sel == 5'h04;
    endproperty
    a_core_pll: assert property (p_core_pll) else $error("core 010 not pll");

    property p_core_lirc;
        core_code_reg == `CCS_C_LIRC |=> core_sel == 5'h08;
    endproperty
    a_core_lirc: assert property (p_core_lirc) else $error("core 011 not lirc");

    property p_core_hirc;
        core_code_reg == `CCS_C_HIRC |=> core_sel == 5'h10;
    endproperty
    a_core_hirc: assert property (p_core_hirc) else $error("core 111 not hirc");

    property p_tick_hxt2;
        tick_code_reg == `CCS_T_HXT2 && !tick_src_is_core |=> tick_sel == 5'h04;
    endproperty
    a_tick_hxt2: assert property (p_tick_hxt2) else $error("tick 010 wrong");

    property p_tick_hclk2;
        tick_code_reg == `CCS_T_HCLK2 && !tick_src_is_core |=> tick_sel == 5'h08;
    endproperty
    a_tick_hclk2: assert property (p_tick_hclk2) else $error("tick 011 wrong");

    property p_tick_hirc2;
        tick_code_reg == `CCS_C_HIRC && !tick_src_is_core |=> tick_sel == 5'h10;
    endproperty
    a_tick_hirc2: assert property (p_tick_hirc2) else $error("tick 111 wrong");

    property p_tick_gate;
        tick_src_is_core |=> tick_sel == 5'h00;
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("tick select while bit 2 set");

    property p_protect;
        boot_done_reg && !unlocked |=> $stable(core_code_reg) && $stable(tick_code_reg);
    endproperty
    a_protect: assert property (p_protect) else $error("locked field changed");

    property p_boot;
        $rose(boot_done_reg) |-> core_code_reg ==
            (($past(boot_clock_config_field) == `CCS_C_HXT) ? `CCS_C_HXT : `CCS_C_HIRC);
    endproperty
    a_boot: assert property (p_boot) else $error("boot value not 000 or 111");

    property p_fail;
        core_switch |=> fail_reg == !(|(core_dec_w(core_code_reg) & $past(stb_sync_reg)));
    endproperty
    a_fail: assert property (p_fail) else $error("fail flag wrong after switch");

    property p_clear;
        fail_clear && !core_switch |=> !fail_reg ##1 (!fail_reg || $past(core_switch));
    endproperty
    a_clear: assert property (p_clear) else $error("fail flag not cleared");

    property p_resv;
        arvalid && arready && araddr == `CCS_OFF_SEL0 |=> rdata[31:6] == 26'h000_0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
endmodule : ccs_top
`default_nettype wire

// ===== verification/ccs_testbench.sv
`include "ccs_params.svh"
`default_nettype none
module testbench
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tick_src_is_core;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot, boot_clock_config_field, core, tick;
    logic [31:0] wdata, rdata, rd, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [4:0] osc_stable, core_sel, tick_sel;
    logic [2:0] codes [6];
    int n_mismatch, check_count, cycles;

    ccs_top uut (.clock(clock), .rstn(rstn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .boot_clock_config_field(boot_clock_config_field),
        .tick_src_is_core(tick_src_is_core), .osc_stable(osc_stable),
        .core_sel(core_sel), .tick_sel(tick_sel));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ==========================================================
    // helpers
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // one-hot order shared by both selects: hxt, lxt, code 2, code 3, code 7
    function logic [4:0] sel_of(input logic [2:0] c);
        case (c)
            3'h0: return 5'h01;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h08;
            3'h7: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction : sel_of

    task results();
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && n < 100);
        r = bresp;
        bready <= 1'b0;
        chk({31'h0, n < 100}, 32'h1, "write answer");
    endtask : axw

    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk({31'h0, n < 100}, 32'h1, "read answer");
    endtask : axr

    task keys(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        axw(`CCS_OFF_UNLOCK, {24'h0, a}, 4'hF, rs);
        axw(`CCS_OFF_UNLOCK, {24'h0, b}, 4'hF, rs);
        axw(`CCS_OFF_UNLOCK, {24'h0, c}, 4'hF, rs);
    endtask : keys

    // hang guard at 20000 cycles: the whole sequence needs well under 2000 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            results();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, tick_src_is_core} = 6'h00;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        boot_clock_config_field = 3'h0;
        osc_stable = 5'h1F;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        seed = 32'h95D4;
        codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        axr(`CCS_OFF_SEL0, rd, rs);
        chk(rd, 32'h38, "select after reset");
        chk({27'h0, core_sel}, 32'h01, "core select after reset");
        chk({27'h0, tick_sel}, 32'h10, "tick select after reset");
        // locked, then a key sequence in the wrong order
        axw(`CCS_OFF_SEL0, 32'h09, 4'hF, rs);
        chk({30'h0, rs}, 32'h0, "locked write response");
        keys(8'h16, 8'h59, 8'h88);
        axw(`CCS_OFF_SEL0, 32'h09, 4'hF, rs);
        axr(`CCS_OFF_SEL0, rd, rs);
        chk(rd, 32'h38, "locked write ignored");
        axr(`CCS_OFF_UNLOCK, rd, rs);
        chk(rd, 32'h0, "still locked");
        keys(8'h59, 8'h16, 8'h88);
        axr(`CCS_OFF_UNLOCK, rd, rs);
        chk(rd, 32'h1, "unlocked");
        // codes 0, 1, 2, 3, 7 and 4 in both fields, target alternately stable and not
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            core = codes[i];
            tick = codes[(i + 3) % 6];
            // sources count as enabled; the other stable bits come from the seed, only the target's bit is forced
            osc_stable <= i[0] ? (seed[4:0] | sel_of(core)) : (seed[4:0] & ~sel_of(core));
            repeat (3) @(posedge clock);
            axw(`CCS_OFF_SEL0, {seed[31:6], tick, core}, 4'hF, rs);
            axr(`CCS_OFF_SEL0, rd, rs);
            chk(rd, {26'h0, tick, core}, "select readback");
            chk({27'h0, core_sel}, {27'h0, sel_of(core)}, "core sel");
            chk({27'h0, tick_sel}, {27'h0, sel_of(tick)}, "tick sel");
            axr(`CCS_OFF_STATUS, rd, rs);
            chk(rd, {24'h0, (sel_of(core) & osc_stable) == 5'h0, 2'h0, osc_stable},
                "status after switch");
        end
        axw(`CCS_OFF_STATUS, 32'h80, 4'hF, rs);
        axr(`CCS_OFF_STATUS, rd, rs);
        chk(rd & 32'h80, 32'h0, "fail flag cleared");
        tick_src_is_core <= 1'b1;
        repeat (3) @(posedge clock);
        chk({27'h0, tick_sel}, 32'h0, "tick select idle");
        tick_src_is_core <= 1'b0;
        // byte lane 0 disabled leaves both fields alone
        axw(`CCS_OFF_SEL0, 32'h0, 4'hE, rs);
        axr(`CCS_OFF_SEL0, rd, rs);
        chk(rd, 32'h14, "strobe off ignored");
        axw(8'h20, 32'h1, 4'hF, rs);
        chk({30'h0, rs}, 32'h2, "unmapped write");
        axr(8'h24, rd, rs);
        chk({rd[29:0], rs}, 32'h2, "unmapped read");
        // a non-key byte closes protection again
        axw(`CCS_OFF_UNLOCK, 32'h0, 4'hF, rs);
        axw(`CCS_OFF_SEL0, 32'h0, 4'hF, rs);
        axr(`CCS_OFF_SEL0, rd, rs);
        chk(rd, 32'h14, "relocked write ignored");
        // second reset with a nonzero boot field
        rstn <= 1'b0;
        boot_clock_config_field <= 3'h5;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        axr(`CCS_OFF_SEL0, rd, rs);
        chk(rd, 32'h3F, "select after second reset");
        chk({27'h0, core_sel}, 32'h10, "core select after second reset");
        results();
    end
endmodule : testbench
`default_nettype wire
